//--- tcc_pkg.sv
package tcc_pkg;
    localparam int NUM_CH = 32;
    localparam int SAMPLE_W = 10;
    localparam int ET_W = 8;
    localparam int HIST_DEPTH = 512;
    localparam int PTR_W = 9;
    localparam int BC_W = 16;
    localparam int TURN_W = 16;
    localparam int BURST_W = 8;
    localparam int FRAME_W = 10;
    localparam int FRAME_SHORT = 8;
    localparam int FRAME_LONG = 10;
    localparam int CLOCK_MHZ = 40;
    localparam int BUF_DEPTH = 2;
    localparam logic [BURST_W-1:0] BURST_RESET = 8'h14;
    localparam logic [31:0] THRESH_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        TCC_RUN,
        TCC_FROZEN,
        TCC_SEND_BC,
        TCC_SEND_TURN,
        TCC_SEND_RAW
    } tcc_state_t;
endpackage : tcc_pkg

//--- tcc_skid.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry buffer so a receiver stall drops no word it has taken
module tcc_skid #(
    parameter int WIDTH = 12
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    import tcc_pkg::*;

    typedef struct packed {
        logic [1:0] count;
        logic [WIDTH-1:0] head;
        logic [WIDTH-1:0] tail;
    } tcc_skid_t;

    tcc_skid_t s;
    tcc_skid_t next_s;
    logic push;
    logic pop;

    always_comb
    begin
        next_s = s;
        push = i_valid && (s.count != 2'(BUF_DEPTH));
        pop = i_ready && (s.count != 2'h0);
        if (pop)
        begin
            next_s.head = s.tail;
        end
        if (push)
        begin
            if (s.count == 2'h0 || (s.count == 2'h1 && pop))
            begin
                next_s.head = i_data;
            end
            else
            begin
                next_s.tail = i_data;
            end
        end
        next_s.count = s.count + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign o_ready = (s.count != 2'(BUF_DEPTH));
    assign o_valid = (s.count != 2'h0);
    assign o_data = s.head;
endmodule : tcc_skid
`default_nettype wire

//--- tcc_trigger_capture.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R01 - channel self-trigger when sample exceeds threshold
// R02 - OR all self-triggers onto crate line
// R03 - redistributed self-trigger freezes history when enabled
// R04 - frozen buffers readable; resume order restarts recording
// R05 - software write raises trigger sent to fanout
// R06 - qualified accept freezes until software resume
// R07 - filter output keeps flowing while frozen
// R08 - controller sends no qualified request while frozen
// R09 - forwarding off: unqualified accepts ignored
// R10 - forwarding on: accept freezes, latches counters
// R11 - accept loads burst counter with sample count
// R12 - burst switches source, sets ten-bit frame flag
// R13 - send crossing, turn, samples until counter zero
// R14 - burst end: filter stream, auto resume unless qualified
// R15 - accepts while frozen capture and send nothing
// R16 - each trigger source has its own enable
// R17 - calibration mode records until self or software trigger
// R18 - all logic on one fast clock
// R19 - thirty-two independent channels
// R20 - slow-control target only, 24-bit address 16-bit data; here a 5-bit channel, 9-bit address, 10-bit data read port
// R21 - circular history of 512 samples with results
// R22 - link carries framing, frame-size and parity bits
// R23 - resume clears every freeze, continues at pointer
module tcc_trigger_capture #(
    parameter int NCH = tcc_pkg::NUM_CH,
    parameter int DEPTH = tcc_pkg::HIST_DEPTH
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [tcc_pkg::NUM_CH*tcc_pkg::SAMPLE_W-1:0] i_raw_sample,
    input wire logic [tcc_pkg::NUM_CH*tcc_pkg::SAMPLE_W-1:0] i_threshold,
    input wire logic [tcc_pkg::ET_W-1:0] i_filter_result,
    input wire logic i_self_trig_en,
    input wire logic i_soft_trig_en,
    input wire logic i_level_one_accept_en,
    input wire logic i_monitoring_qualifier_en,
    input wire logic i_forward_en,
    input wire logic i_calib_mode,
    input wire logic [tcc_pkg::BURST_W-1:0] i_burst_len,
    input wire logic i_soft_trig_write,
    input wire logic i_sync_self_trig,
    input wire logic i_sync_soft_trig,
    input wire logic i_sync_resume,
    input wire logic i_level_one_accept,
    input wire logic i_monitoring_qualifier,
    input wire logic i_beam_crossing_tick,
    input wire logic i_turn_marker,
    input wire logic [tcc_pkg::PTR_W-1:0] i_rd_addr,
    input wire logic [4:0] i_rd_chan,
    input wire logic i_link_ready,
    output logic o_self_trig_or,
    output logic o_soft_trig_req,
    output logic o_frozen,
    output logic o_recording,
    output logic o_bursting,
    output logic [tcc_pkg::PTR_W-1:0] o_wr_ptr,
    output logic [tcc_pkg::SAMPLE_W-1:0] o_rd_data,
    output logic o_link_valid,
    output logic [tcc_pkg::FRAME_W-1:0] o_link_data,
    output logic o_link_lsb,
    output logic o_link_long,
    output logic o_link_parity,
    output logic o_burst_stall
);
    import tcc_pkg::*;

    localparam int LINK_W = FRAME_W + 1;

    typedef struct packed {
        tcc_state_t state;
        logic qualified;
        logic self_or;
        logic soft_req;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [BURST_W-1:0] burst_cnt;
        logic [BC_W-1:0] bc_cnt;
        logic [TURN_W-1:0] turn_cnt;
        logic [BC_W-1:0] bc_shift;
        logic [TURN_W-1:0] turn_shift;
        logic half;
        logic [SAMPLE_W-1:0] rd_data;
        logic lsb;
        logic parity;
        logic long_frame;
        logic link_valid;
        logic [FRAME_W-1:0] link_data;
        logic rec;
        logic frozen;
        logic bursting;
    } tcc_core_t;

    tcc_core_t s;
    tcc_core_t next_s;

    // history: raw sample plus filter result, flop storage
    logic [SAMPLE_W+ET_W-1:0] hist [NCH][DEPTH];

    logic [NCH-1:0] over;
    logic recording;
    logic freeze_now;
    logic take_accept;
    logic sync_trig;
    logic advance;
    logic out_take;
    logic buf_ready;
    logic buf_in_valid;
    logic [LINK_W-1:0] buf_in_data;
    logic buf_out_valid;
    logic [LINK_W-1:0] buf_out_data;

    function automatic logic [SAMPLE_W-1:0] chan_word(
        input logic [NUM_CH*SAMPLE_W-1:0] bus,
        input int ch
    );
        chan_word = bus[ch*SAMPLE_W +: SAMPLE_W];
    endfunction : chan_word

    always_comb
    begin
        for (int c = 0; c < NCH; c++)
        begin
            over[c] = chan_word(i_raw_sample, c) > chan_word(i_threshold, c); // R01 R19
        end
    end

    assign recording = (s.state == TCC_RUN);
    // accepts only count in running state; frozen ones are dropped
    assign take_accept = recording && i_level_one_accept_en && i_level_one_accept
        && (i_forward_en || (i_monitoring_qualifier && i_monitoring_qualifier_en)); // R09 R15 R16
    assign sync_trig = (i_sync_self_trig && i_self_trig_en)
        || (i_sync_soft_trig && i_soft_trig_en); // R16
    // a burst word is only replaced once the buffer took it, else a stall drops it
    assign advance = !s.link_valid || buf_ready;

    always_comb
    begin
        next_s = s;
        freeze_now = 1'b0;
        next_s.self_or = i_self_trig_en && (|over); // R02 R16
        next_s.soft_req = i_soft_trig_en && i_soft_trig_write; // R05 R16
        if (i_beam_crossing_tick)
        begin
            next_s.bc_cnt = s.bc_cnt + 1'b1;
        end
        if (i_turn_marker)
        begin
            next_s.bc_cnt = '0;
            next_s.turn_cnt = s.turn_cnt + 1'b1;
        end
        if (recording)
        begin
            next_s.wr_ptr = s.wr_ptr + 1'b1; // R21
        end
        next_s.rd_data = hist[i_rd_chan][i_rd_addr][SAMPLE_W+ET_W-1:ET_W]; // R04 R20
        // default: filter stream keeps running, frozen included; the burst send states replace it
        next_s.link_valid = 1'b1; // R07
        next_s.link_data = {2'h0, i_filter_result};
        next_s.long_frame = 1'b0;
        next_s.lsb = ~s.lsb; // R22
        next_s.parity = ^{2'h0, i_filter_result}; // R22
        case (s.state)
            TCC_RUN:
            begin
                if (sync_trig)
                begin
                    freeze_now = 1'b1; // R03 R17
                    next_s.qualified = 1'b1;
                    next_s.state = TCC_FROZEN;
                end
                else if (take_accept)
                begin
                    next_s.qualified = i_monitoring_qualifier && i_monitoring_qualifier_en; // R06
                    if (i_forward_en)
                    begin
                        next_s.bc_shift = s.bc_cnt; // R10
                        next_s.turn_shift = s.turn_cnt; // R10
                        next_s.burst_cnt = i_burst_len; // R11
                        next_s.rd_ptr = s.wr_ptr - PTR_W'(i_burst_len);
                        next_s.half = 1'b0;
                        next_s.state = TCC_SEND_BC;
                    end
                    else
                    begin
                        next_s.state = TCC_FROZEN; // R06
                    end
                end
                // calibration mode only stops on self/soft triggers above
                if (i_calib_mode && !freeze_now)
                begin
                    next_s.state = TCC_RUN; // R17
                end
            end
            TCC_FROZEN:
            begin
                if (i_sync_resume)
                begin
                    next_s.state = TCC_RUN; // R04 R23
                    next_s.qualified = 1'b0;
                end
            end
            TCC_SEND_BC:
            begin
                if (advance)
                begin
                    next_s.long_frame = 1'b1; // R12
                    next_s.link_data = {2'h0, s.bc_shift[8*s.half +: 8]}; // R13
                    next_s.parity = ^s.bc_shift[8*s.half +: 8];
                    next_s.half = ~s.half;
                    if (s.half)
                    begin
                        next_s.state = TCC_SEND_TURN;
                    end
                end
            end
            TCC_SEND_TURN:
            begin
                if (advance)
                begin
                    next_s.long_frame = 1'b1; // R12
                    next_s.link_data = {2'h0, s.turn_shift[8*s.half +: 8]}; // R13
                    next_s.parity = ^s.turn_shift[8*s.half +: 8];
                    next_s.half = ~s.half;
                    if (s.half)
                    begin
                        next_s.state = TCC_SEND_RAW;
                    end
                end
            end
            TCC_SEND_RAW:
            begin
                if (s.burst_cnt == '0)
                begin
                    // R14: auto resume unless qualified
                    next_s.state = s.qualified ? TCC_FROZEN : TCC_RUN; // R14
                end
                else if (advance)
                begin
                    next_s.long_frame = 1'b1; // R12
                    next_s.link_data = hist[i_rd_chan][s.rd_ptr][SAMPLE_W+ET_W-1:ET_W]; // R12
                    next_s.parity = ^hist[i_rd_chan][s.rd_ptr][SAMPLE_W+ET_W-1:ET_W];
                    next_s.rd_ptr = s.rd_ptr + 1'b1;
                    next_s.burst_cnt = s.burst_cnt - 1'b1; // R13
                end
            end
            default:
            begin
                next_s.state = TCC_RUN;
            end
        endcase
        // a resume order clears any freeze, even mid-burst; a fresh trigger wins
        if (i_sync_resume && s.state != TCC_RUN)
        begin
            next_s.state = sync_trig ? TCC_FROZEN : TCC_RUN; // R23
            next_s.qualified = sync_trig;
        end
        // a pending burst word is held, never overwritten by the filter stream
        if (!advance && (s.long_frame || s.bursting))
        begin
            next_s.link_valid = s.link_valid;
            next_s.link_data = s.link_data;
            next_s.long_frame = s.long_frame;
            next_s.parity = s.parity;
        end
        next_s.rec = (next_s.state == TCC_RUN);
        next_s.frozen = (next_s.state == TCC_FROZEN);
        next_s.bursting = !next_s.rec && !next_s.frozen;
    end

    assign buf_in_valid = s.link_valid;
    assign buf_in_data = {s.long_frame, s.link_data};
    // output word stands until the far side takes it
    assign out_take = !o_link_valid || i_link_ready;

    tcc_skid #(
        .WIDTH(LINK_W)
    ) u_skid (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_valid(buf_in_valid),
        .o_ready(buf_ready),
        .i_data(buf_in_data),
        .o_valid(buf_out_valid),
        .i_ready(out_take),
        .o_data(buf_out_data)
    );

    // history write; single clock domain at the fast rate
    always_ff @(posedge i_clock)
    begin
        if (recording)
        begin
            for (int c = 0; c < NCH; c++)
            begin
                hist[c][s.wr_ptr] <= {chan_word(i_raw_sample, c), i_filter_result}; // R21 R18
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            s <= '0;
            s.state <= TCC_RUN;
            s.rec <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_link_valid <= 1'b0;
            o_link_data <= '0;
            o_link_long <= 1'b0;
            o_link_lsb <= 1'b0;
            o_link_parity <= 1'b0;
            o_burst_stall <= 1'b0;
        end
        else
        begin
            if (out_take)
            begin
                o_link_valid <= buf_out_valid;
                o_link_data <= buf_out_data[FRAME_W-1:0];
                o_link_long <= buf_out_data[FRAME_W]; // R12
                o_link_parity <= ^buf_out_data; // R22
            end
            o_link_lsb <= s.lsb; // R22
            o_burst_stall <= !buf_ready;
        end
    end

    assign o_self_trig_or = s.self_or;
    assign o_soft_trig_req = s.soft_req;
    assign o_frozen = s.frozen;
    assign o_recording = s.rec;
    assign o_bursting = s.bursting;
    assign o_wr_ptr = s.wr_ptr;
    assign o_rd_data = s.rd_data;
endmodule : tcc_trigger_capture
`default_nettype wire

//--- tcc_trigger_capture_checker.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_trigger_capture_checker
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [tcc_pkg::NUM_CH*tcc_pkg::SAMPLE_W-1:0] i_raw_sample,
    input wire logic [tcc_pkg::NUM_CH*tcc_pkg::SAMPLE_W-1:0] i_threshold,
    input wire logic i_self_trig_en,
    input wire logic i_soft_trig_en,
    input wire logic i_level_one_accept_en,
    input wire logic i_forward_en,
    input wire logic i_calib_mode,
    input wire logic i_soft_trig_write,
    input wire logic i_sync_self_trig,
    input wire logic i_sync_soft_trig,
    input wire logic i_sync_resume,
    input wire logic i_level_one_accept,
    input wire logic o_self_trig_or,
    input wire logic o_soft_trig_req,
    input wire logic o_frozen,
    input wire logic o_recording,
    input wire logic o_bursting,
    input wire logic [tcc_pkg::PTR_W-1:0] o_wr_ptr
);
    import tcc_pkg::*;
    logic over;
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    always_comb
    begin
        over = 1'b0;
        for (int c = 0; c < NUM_CH; c++)
        begin
            over |= i_raw_sample[c*SAMPLE_W+:SAMPLE_W] > i_threshold[c*SAMPLE_W+:SAMPLE_W];
        end
    end
    property p_self_or;
        o_self_trig_or == ($past(over) && $past(i_self_trig_en));
    endproperty
    a_self_or: assert property (p_self_or) else $error("self trigger or wrong");
    property p_soft_req;
        o_soft_trig_req == ($past(i_soft_trig_write) && $past(i_soft_trig_en));
    endproperty
    a_soft_req: assert property (p_soft_req) else $error("soft request wrong");
    property p_self_freeze;
        i_sync_self_trig && i_self_trig_en && !i_sync_resume && !o_bursting |=> o_frozen;
    endproperty
    a_self_freeze: assert property (p_self_freeze) else $error("no freeze");
    property p_resume;
        (o_frozen || o_bursting) && i_sync_resume && !(i_sync_self_trig && i_self_trig_en)
            && !(i_sync_soft_trig && i_soft_trig_en) |=> o_recording;
    endproperty
    a_resume: assert property (p_resume) else $error("resume ignored");
    property p_hold;
        o_frozen && !i_sync_resume |=> o_frozen;
    endproperty
    a_hold: assert property (p_hold) else $error("freeze dropped");
    property p_no_rec;
        !o_recording |=> $stable(o_wr_ptr);
    endproperty
    a_no_rec: assert property (p_no_rec) else $error("recording while held");
    property p_ptr_step;
        o_recording |=> o_wr_ptr == $past(o_wr_ptr) + 1'b1;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("write pointer stuck");
    property p_burst_start;
        i_level_one_accept && i_level_one_accept_en && i_forward_en && !i_calib_mode
            && !o_frozen && !o_bursting && !i_sync_resume && !i_sync_self_trig
            && !i_sync_soft_trig |=> o_bursting;
    endproperty
    a_burst_start: assert property (p_burst_start) else $error("no burst");
    property p_burst_end;
        $rose(o_bursting) |-> ##[1:400] !o_bursting;
    endproperty
    a_burst_end: assert property (p_burst_end) else $error("burst hangs");
    c_burst: cover property (o_bursting ##1 !o_bursting);
    c_resume: cover property (o_frozen ##1 !o_frozen);
    c_soft: cover property (o_soft_trig_req);
endmodule : tcc_trigger_capture_checker
bind tcc_trigger_capture tcc_trigger_capture_checker chk_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_raw_sample(i_raw_sample),
    .i_threshold(i_threshold), .i_self_trig_en(i_self_trig_en),
    .i_soft_trig_en(i_soft_trig_en), .i_level_one_accept_en(i_level_one_accept_en),
    .i_forward_en(i_forward_en), .i_calib_mode(i_calib_mode),
    .i_soft_trig_write(i_soft_trig_write), .i_sync_self_trig(i_sync_self_trig),
    .i_sync_soft_trig(i_sync_soft_trig), .i_sync_resume(i_sync_resume),
    .i_level_one_accept(i_level_one_accept), .o_self_trig_or(o_self_trig_or),
    .o_soft_trig_req(o_soft_trig_req), .o_frozen(o_frozen),
    .o_recording(o_recording), .o_bursting(o_bursting), .o_wr_ptr(o_wr_ptr)
);
`default_nettype wire

//--- tcc_link_sink.sv
`timescale 1ns/10ps
`default_nettype none
// downstream board: takes words at will, stalls at random
module tcc_link_sink
(
    input wire logic i_clock,
    input wire logic i_hold,
    output logic o_ready
);
    int seed = 32'h3e263d4c;
    initial o_ready = 1'b1;
    always @(negedge i_clock)
        o_ready <= !i_hold && ($random(seed) % 4 != 0);
endmodule : tcc_link_sink
`default_nettype wire

//--- tcc_trigger_capture_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tcc_trigger_capture_tb;
    import tcc_pkg::*;
    localparam logic [SAMPLE_W-1:0] K = 10'h155;
    localparam logic [SAMPLE_W-1:0] THR = 10'h200;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic [NUM_CH*SAMPLE_W-1:0] raw = {NUM_CH{K}};
    logic [ET_W-1:0] filt = 8'h00;
    logic se, te, ae, qe, fwd, cal, sw, ss, st, sr, acc, q, hold, fq, tk, fz;
    logic [BURST_W-1:0] len = 8'h01;
    logic [PTR_W-1:0] rd_addr = 9'h000;
    logic [FRAME_W-1:0] got[$];
    logic bct = 1'b0;
    logic tmk = 1'b0;
    logic [BC_W-1:0] bc_m;
    logic [TURN_W-1:0] turn_m;
    logic [31:0] hdr;
    wire logic rdy, self_or, soft_req, frozen, rec, bursting, stall, lvalid, llsb, llong, lpar;
    wire logic [PTR_W-1:0] wr_ptr;
    wire logic [SAMPLE_W-1:0] rd_data;
    wire logic [FRAME_W-1:0] ldata;
    int err_total = 0;
    int n_compared = 0;
    int seed = 32'h3e263d4c;
    int c;
    always #12.5 i_clock = ~i_clock;
    always @(negedge i_clock)
    begin
        filt <= 8'($random(seed));
        bct <= 1'($random(seed));
        tmk <= ($random(seed) % 997) == 0;
    end
    always @(posedge i_clock)
    begin
        if (!i_rst && lvalid)
            check(lpar, ^{llong, ldata});
        if (!i_rst && lvalid && rdy && llong)
            got.push_back(ldata);
    end
    // crossing and turn counters kept as the rules describe them
    always @(posedge i_clock)
    begin
        if (i_rst || tmk)
            bc_m <= '0;
        else if (bct)
            bc_m <= bc_m + 16'h1;
        if (i_rst)
            turn_m <= '0;
        else if (tmk)
            turn_m <= turn_m + 16'h1;
    end
    tcc_link_sink sink_u (.i_clock(i_clock), .i_hold(hold), .o_ready(rdy));
    tcc_trigger_capture dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_raw_sample(raw), .i_threshold({NUM_CH{THR}}),
        .i_filter_result(filt), .i_self_trig_en(se), .i_soft_trig_en(te),
        .i_level_one_accept_en(ae), .i_monitoring_qualifier_en(qe), .i_forward_en(fwd),
        .i_calib_mode(cal), .i_burst_len(len), .i_soft_trig_write(sw),
        .i_sync_self_trig(ss), .i_sync_soft_trig(st), .i_sync_resume(sr),
        .i_level_one_accept(acc), .i_monitoring_qualifier(q), .i_beam_crossing_tick(bct),
        .i_turn_marker(tmk), .i_rd_addr(rd_addr), .i_rd_chan(5'h00), .i_link_ready(rdy),
        .o_self_trig_or(self_or), .o_soft_trig_req(soft_req), .o_frozen(frozen),
        .o_recording(rec), .o_bursting(bursting), .o_wr_ptr(wr_ptr), .o_rd_data(rd_data),
        .o_link_valid(lvalid), .o_link_data(ldata), .o_link_lsb(llsb), .o_link_long(llong),
        .o_link_parity(lpar), .o_burst_stall(stall));
    task automatic step(input int n);
        repeat (n) @(negedge i_clock);
    endtask : step
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic resume;
        sr = 1;
        step(1);
        sr = 0;
        check(frozen, 0);
    endtask : resume
    task automatic tally_and_finish;
        $display("errors %0d, compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #(25 * 20000);
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        {se, te, ae, qe, fwd, cal, sw, ss, st, sr, acc, q, hold, fq} = '0;
        step(3);
        i_rst = 0;
        step(600);
        check(rec, 1);
        c = llsb;
        step(1);
        check(llsb, !c[0]);
        for (int k = 0; k < 6; k++)
        begin
            se = k[0];
            te = k[0];
            c = 1 + $unsigned($random(seed)) % 31;
            // equal to threshold must not count as over
            raw[c*SAMPLE_W+:SAMPLE_W] = k < 2 ? THR : 10'h3ff;
            sw = 1;
            step(1);
            {sw, ss, st} = {1'b0, k < 4, k >= 4};
            raw = {NUM_CH{K}};
            check(self_or, se && k > 1);
            check(soft_req, te);
            rd_addr = 9'($random(seed));
            step(1);
            {ss, st} = '0;
            step(1);
            check(frozen, se);
            check(rd_data, K);
            c = wr_ptr;
            step(1);
            check(wr_ptr, se ? 9'(c) : 9'(c + 1));
            resume();
            step(1);
            check(rec, 1);
        end
        {cal, ae, fwd, acc} = '1;
        step(1);
        {acc, ss} = 2'b01;
        step(1);
        ss = 0;
        check(bursting, 0);
        step(1);
        check(frozen, 1);
        resume();
        cal = 0;
        for (int k = 0; k < 16; k++)
        begin
            {ae, qe, fq, fwd} = k[3:0];
            len = 8'(1 + $unsigned($random(seed)) % 4);
            tk = ae && (fwd || (fq && qe));
            fz = tk && fq && qe;
            hold = k == 15;
            got.delete();
            {q, acc} = {fq, 1'b1};
            hdr = {turn_m, bc_m};
            step(1);
            {acc, q} = '0;
            check(bursting, tk && fwd);
            check(rec, !tk);
            if (hold)
            begin
                step(12);
                check(stall, 1);
                hold = 0;
            end
            for (int w = 0; w < 400 && bursting; w++)
                step(1);
            step(30);
            check(got.size(), tk && fwd ? len + 4 : 0);
            foreach (got[i])
                check(got[i], i < 4 ? 16'(hdr[8*i +: 8]) : 16'(K));
            check(frozen, fz);
            if (fz)
            begin
                c = got.size();
                // only an unqualified accept may come while held
                {fwd, acc} = 2'b11;
                step(1);
                acc = 0;
                step(30);
                check(got.size(), c);
                resume();
            end
        end
        tally_and_finish();
    end
endmodule : tcc_trigger_capture_tb
`default_nettype wire
